/* File: rtl/ipds_regs.vh */
`ifndef IPDS_REGS_VH
`define IPDS_REGS_VH
`define IPDS_ICR_LO_ADDR   6'h00
`define IPDS_ICR_HI_ADDR   6'h04
`define IPDS_LDR_ADDR      6'h08
`define IPDS_DFR_ADDR      6'h0c
`define IPDS_MSG_ADDR      6'h10
`define IPDS_RX_ADDR       6'h14
`define IPDS_ID_ADDR       6'h18
`define IPDS_DFR_RESET     32'hffffffff
`define IPDS_DM_FIXED      3'h0
`define IPDS_DM_LOWEST     3'h1
`define IPDS_DM_SMI        3'h2
`define IPDS_DM_NMI        3'h4
`define IPDS_DM_INIT       3'h5
`define IPDS_DM_STARTUP    3'h6
`define IPDS_SH_NONE       2'h0
`define IPDS_SH_SELF       2'h1
`define IPDS_SH_ALL_INCL   2'h2
`define IPDS_SH_ALL_EXCL   2'h3
`define IPDS_MODEL_FLAT    4'hf
`define IPDS_MODEL_CLUSTER 4'h0
`define IPDS_BCAST_NEW     8'hff
`define IPDS_BCAST_OLD     8'h0f
`define IPDS_BIT_LEVEL     14
`define IPDS_BIT_TRIG      15
`define IPDS_BIT_DESTMODE  11
`define IPDS_BIT_STATUS    12
`endif

/* File: rtl/ipds_match.v */
`include "ipds_regs.vh"
module ipds_match
(
  input  wire [7:0] message_destination_address,
  input  wire [7:0] logical_id,
  input  wire [3:0] model,
  output wire       hit
);
  // -----------------------------------------------------------------
  // Logical address match.
  // -----------------------------------------------------------------
  wire flat_hit;
  wire clus_hit;
  assign flat_hit = |(message_destination_address & logical_id);
  assign clus_hit = ((message_destination_address[7:4] == logical_id[7:4]) || (message_destination_address[7:4] == 4'hf))
                    && |(message_destination_address[3:0] & logical_id[3:0]);
  assign hit = (model == `IPDS_MODEL_FLAT)    ? flat_hit :
               (model == `IPDS_MODEL_CLUSTER) ? clus_hit : 1'b0;
endmodule

/* File: rtl/ipds_top.v */
`include "ipds_regs.vh"
module ipds_top
#(
  parameter NEWER_VARIANT = 1
)
(
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        aclk_en,
  input  wire [5:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [5:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg         msg_valid,
  input  wire        msg_ready,
  output reg  [7:0]  msg_vector,
  output reg  [2:0]  msg_delivery,
  output reg         msg_logical,
  output reg         msg_level,
  output reg         msg_trigger,
  output reg  [7:0]  msg_dest,
  output reg         msg_incl_self,
  output reg         msg_excl_self,
  input  wire        rx_valid,
  input  wire [7:0]  rx_dest,
  input  wire        rx_logical,
  input  wire        rx_excl_sender,
  output reg         rx_accept
);
  // -----------------------------------------------------------------
  // Register state.
  // -----------------------------------------------------------------
  reg [31:0] icr_lo_r;
  reg [31:0] icr_hi_r;
  reg [31:0] ldr_r;
  reg [31:0] dfr_r;
  reg [7:0]  phys_id_r;
  reg [7:0]  drop_cnt_r;
  reg [7:0]  rx_cnt_r;
  reg        aw_held_r;
  reg        w_held_r;
  reg [5:0]  aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0]  w_strb_r;
  reg        rx_valid_s1_r;
  reg        rx_valid_s2_r;
  reg [7:0]  rx_dest_s1_r;
  reg [7:0]  rx_dest_s2_r;
  reg        rx_log_s1_r;
  reg        rx_log_s2_r;
  reg        rx_ex_s1_r;
  reg        rx_ex_s2_r;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          merge[i*8 +: 8] = data[i*8 +: 8];
    end
  endfunction

  function is_bcast;
    input [7:0] id;
    begin
      if (NEWER_VARIANT != 0)
        is_bcast = (id == `IPDS_BCAST_NEW);
      else
        is_bcast = (id == `IPDS_BCAST_OLD);
    end
  endfunction

  // -----------------------------------------------------------------
  // Write channel of the bus slave.
  // -----------------------------------------------------------------
  wire       wr_go;
  wire [5:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire [31:0] id_merged;
  // Ready stays low while the clock enable freezes the slave.
  assign s_axi_awready = aclk_en && !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready  = aclk_en && !w_held_r && !s_axi_bvalid;
  assign id_merged = merge({24'h000000, phys_id_r}, wr_data, wr_strb);
  assign wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
  assign wr_data = w_held_r ? w_data_r : s_axi_wdata;
  assign wr_strb = w_held_r ? w_strb_r : s_axi_wstrb;
  assign wr_go = (aw_held_r || (s_axi_awvalid && s_axi_awready)) &&
                 (w_held_r || (s_axi_wvalid && s_axi_wready)) &&
                 !s_axi_bvalid;

  // -----------------------------------------------------------------
  // Command check on the pending low word.
  // -----------------------------------------------------------------
  wire [31:0] lo_new;
  wire [2:0]  dm;
  wire [1:0]  sh;
  wire        lvl;
  wire        trg;
  reg         send_ok;
  reg         out_trg;
  reg         out_lvl;
  assign lo_new = merge(icr_lo_r, wr_data, wr_strb);
  assign dm  = lo_new[10:8];
  assign sh  = lo_new[19:18];
  assign lvl = lo_new[`IPDS_BIT_LEVEL];
  assign trg = lo_new[`IPDS_BIT_TRIG];

  always @*
  begin
    send_ok = 1'b1;
    out_trg = 1'b0;
    out_lvl = 1'b1;
    if (NEWER_VARIANT != 0)
    begin
      // Level is always issued high and trigger forced to edge.
      out_trg = 1'b0;
      out_lvl = 1'b1;
      if ((sh == `IPDS_SH_SELF || sh == `IPDS_SH_ALL_INCL) &&
          dm != `IPDS_DM_FIXED)
        send_ok = 1'b0;
    end
    else if (trg)
    begin
      if (dm == `IPDS_DM_INIT)
      begin
        out_trg = 1'b0;
        out_lvl = lvl;
      end
      else if (dm == `IPDS_DM_FIXED || dm == `IPDS_DM_LOWEST ||
               dm == `IPDS_DM_NMI)
        send_ok = lvl;
      else
        send_ok = 1'b0;
    end
    else
      out_lvl = lvl;
    if (NEWER_VARIANT == 0 && (sh == `IPDS_SH_SELF ||
        sh == `IPDS_SH_ALL_INCL) && dm != `IPDS_DM_FIXED)
      send_ok = 1'b0;
  end

  // -----------------------------------------------------------------
  // Register writes and message launch.
  // -----------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      icr_lo_r     <= 32'h00000000;
      icr_hi_r     <= 32'h00000000;
      ldr_r        <= 32'h00000000;
      dfr_r        <= `IPDS_DFR_RESET;
      phys_id_r    <= 8'h00;
      drop_cnt_r   <= 8'h00;
      aw_held_r    <= 1'b0;
      w_held_r     <= 1'b0;
      aw_addr_r    <= 6'h00;
      w_data_r     <= 32'h00000000;
      w_strb_r     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
      msg_valid    <= 1'b0;
      msg_vector   <= 8'h00;
      msg_delivery <= 3'h0;
      msg_logical  <= 1'b0;
      msg_level    <= 1'b0;
      msg_trigger  <= 1'b0;
      msg_dest     <= 8'h00;
      msg_incl_self <= 1'b0;
      msg_excl_self <= 1'b0;
    end
    else if (aclk_en)
    begin
      if (msg_valid && msg_ready)
      begin
        msg_valid <= 1'b0;
        icr_lo_r[`IPDS_BIT_STATUS] <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (s_axi_awvalid && s_axi_awready && !wr_go)
      begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready && !wr_go)
      begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'h0;
        case (wr_addr[5:2])
          4'h0:
          begin
            if (msg_valid)
              s_axi_bresp <= 2'h2;
            else if (send_ok)
            begin
              // The low word write launches the message.
              icr_lo_r <= lo_new;
              icr_lo_r[`IPDS_BIT_STATUS] <= 1'b1;
              msg_valid    <= 1'b1;
              msg_vector   <= lo_new[7:0];
              msg_delivery <= dm;
              msg_level    <= out_lvl;
              msg_trigger  <= out_trg;
              // Shorthand overrides destination mode and field.
              if (sh == `IPDS_SH_NONE)
              begin
                msg_logical <= lo_new[`IPDS_BIT_DESTMODE];
                msg_dest    <= icr_hi_r[31:24];
                msg_incl_self <= 1'b0;
                msg_excl_self <= 1'b0;
              end
              else
              begin
                msg_logical <= 1'b0;
                msg_dest    <= (NEWER_VARIANT != 0) ? `IPDS_BCAST_NEW :
                               `IPDS_BCAST_OLD;
                // Lowest priority to all-but-self may reach the sender.
                msg_incl_self <= (sh != `IPDS_SH_ALL_EXCL) ||
                                 (dm == `IPDS_DM_LOWEST);
                msg_excl_self <= (sh == `IPDS_SH_ALL_EXCL) &&
                                 (dm != `IPDS_DM_LOWEST);
                if (sh == `IPDS_SH_SELF)
                  msg_dest <= phys_id_r;
              end
            end
            else
            begin
              icr_lo_r   <= lo_new;
              icr_lo_r[`IPDS_BIT_STATUS] <= 1'b0;
              drop_cnt_r <= drop_cnt_r + 8'h01;
            end
          end
          4'h1: icr_hi_r <= merge(icr_hi_r, wr_data, wr_strb);
          4'h2: ldr_r <= merge(ldr_r, wr_data, wr_strb) &
                         32'hff000000;
          4'h3: dfr_r <= merge(dfr_r, wr_data, wr_strb) |
                         32'h0fffffff;
          4'h6: phys_id_r <= id_merged[7:0];
          default: s_axi_bresp <= 2'h2;
        endcase
      end
    end
  end

  // -----------------------------------------------------------------
  // Receive path with synchronised inputs.
  // -----------------------------------------------------------------
  wire lhit;
  ipds_match u_match
  (
    .message_destination_address        (rx_dest_s2_r),
    .logical_id (ldr_r[31:24]),
    .model      (dfr_r[31:28]),
    .hit        (lhit)
  );

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_valid_s1_r <= 1'b0;
      rx_valid_s2_r <= 1'b0;
      rx_dest_s1_r  <= 8'h00;
      rx_dest_s2_r  <= 8'h00;
      rx_log_s1_r   <= 1'b0;
      rx_log_s2_r   <= 1'b0;
      rx_ex_s1_r    <= 1'b0;
      rx_ex_s2_r    <= 1'b0;
      rx_accept     <= 1'b0;
      rx_cnt_r      <= 8'h00;
    end
    else if (aclk_en)
    begin
      rx_valid_s1_r <= rx_valid;
      rx_valid_s2_r <= rx_valid_s1_r;
      rx_dest_s1_r  <= rx_dest;
      rx_dest_s2_r  <= rx_dest_s1_r;
      rx_log_s1_r   <= rx_logical;
      rx_log_s2_r   <= rx_log_s1_r;
      rx_ex_s1_r    <= rx_excl_sender;
      rx_ex_s2_r    <= rx_ex_s1_r;
      rx_accept     <= 1'b0;
      if (rx_valid_s2_r && !rx_ex_s2_r)
      begin
        if (rx_log_s2_r ? lhit : (is_bcast(rx_dest_s2_r) ||
            rx_dest_s2_r == phys_id_r))
        begin
          rx_accept <= 1'b1;
          rx_cnt_r  <= rx_cnt_r + 8'h01;
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // Read channel of the bus slave.
  // -----------------------------------------------------------------
  assign s_axi_arready = aclk_en && !s_axi_rvalid;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'h0;
    end
    else if (aclk_en)
    begin
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        case (s_axi_araddr[5:2])
          4'h0: s_axi_rdata <= icr_lo_r;
          4'h1: s_axi_rdata <= icr_hi_r;
          4'h2: s_axi_rdata <= ldr_r;
          4'h3: s_axi_rdata <= dfr_r;
          4'h4: s_axi_rdata <= {24'h0, drop_cnt_r};
          4'h5: s_axi_rdata <= {24'h0, rx_cnt_r};
          4'h6: s_axi_rdata <= {24'h0, phys_id_r};
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end
    end
  end
endmodule

/* File: tb/ipds_sva.sv */
`include "ipds_regs.vh"
module ipds_sva
#(
  parameter NEWER_VARIANT = 1
)
(
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       msg_valid,
  input wire logic       msg_ready,
  input wire logic [2:0] msg_delivery,
  input wire logic       msg_logical,
  input wire logic       msg_level,
  input wire logic       msg_trigger,
  input wire logic [7:0] msg_dest,
  input wire logic       msg_excl_self,
  input wire logic       rx_valid,
  input wire logic       rx_accept
);
  localparam logic [7:0] BCAST = NEWER_VARIANT ? 8'hff : 8'h0f;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_msg_hold;
    msg_valid && !msg_ready |=> msg_valid && $stable(msg_dest)
      && $stable(msg_delivery);
  endproperty
  a_msg_hold: assert property (p_msg_hold)
    else $error("message dropped or changed before it was taken");
  property p_msg_start;
    $rose(msg_valid) |-> $rose(s_axi_bvalid);
  endproperty
  a_msg_start: assert property (p_msg_start)
    else $error("message raised without a command write");
  property p_edge;
    msg_valid |-> !msg_trigger;
  endproperty
  a_edge: assert property (p_edge)
    else $error("message sent level triggered");
  property p_new_level;
    NEWER_VARIANT != 0 && msg_valid |-> msg_level;
  endproperty
  a_new_level: assert property (p_new_level)
    else $error("level bit low on the newer variant");
  property p_old_level;
    msg_valid && !msg_level |-> msg_delivery == `IPDS_DM_INIT;
  endproperty
  a_old_level: assert property (p_old_level)
    else $error("level bit low on a message that is not init");
  property p_excl_phys;
    msg_valid && msg_excl_self |-> !msg_logical && msg_dest == BCAST;
  endproperty
  a_excl_phys: assert property (p_excl_phys)
    else $error("all but sender not a physical broadcast");
  property p_rx_lat;
    rx_accept |-> $past(rx_valid, 3);
  endproperty
  a_rx_lat: assert property (p_rx_lat)
    else $error("accept without a message three cycles before");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response withdrawn early");
  c_msg: cover property (msg_valid && msg_ready);
  c_acc: cover property (rx_accept);
  c_excl: cover property (msg_valid && msg_excl_self);
endmodule
bind ipds_top ipds_sva #(.NEWER_VARIANT(NEWER_VARIANT)) i_sva (.*);

/* File: tb/ipds_peer.sv */
module ipds_peer
(
  input  wire logic       aclk,
  input  wire logic       msg_valid,
  output logic            msg_ready,
  output logic            rx_valid,
  output logic [7:0]      rx_dest,
  output logic            rx_logical,
  output logic            rx_excl_sender
);
  timeunit 1ns;
  timeprecision 1ps;
  int delay = 0;
  int wait_n = 0;
  initial
  begin
    msg_ready = 1'h0;
    rx_valid = 1'h0;
    rx_dest = 8'h5a;
    rx_logical = 1'h0;
    rx_excl_sender = 1'h0;
  end
  always @(posedge aclk)
  begin
    if (msg_valid && msg_ready)
    begin
      msg_ready <= 1'h0;
      wait_n <= 0;
    end
    else if (msg_valid)
    begin
      wait_n <= wait_n + 1;
      msg_ready <= (wait_n >= delay);
    end
  end
  // Released lines show the inverse so stale values never match.
  task automatic send(input logic [7:0] d, input logic lg, ex);
    @(posedge aclk);
    rx_dest <= d;
    rx_logical <= lg;
    rx_excl_sender <= ex;
    rx_valid <= 1'h1;
    repeat (3) @(posedge aclk);
    rx_valid <= 1'h0;
    rx_dest <= ~d;
    rx_logical <= ~lg;
    rx_excl_sender <= ~ex;
  endtask
endmodule

/* File: tb/ipi_destination_select_tb.sv */
`include "ipds_regs.vh"
`define CHK(n, e, v) begin compares++; if ((v) !== (e)) begin \
  err_count++; $display("wrong value %s exp %h got %h", n, e, v); end end
module ipi_destination_select_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'h0, aresetn = 1'h0, aclk_en = 1'h1;
  logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, msg_valid, msg_ready, msg_logical, msg_level;
  wire msg_trigger, msg_incl_self, msg_excl_self, rx_valid, rx_logical;
  wire rx_excl_sender, rx_accept;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0] msg_vector, msg_dest, rx_dest;
  wire [2:0] msg_delivery;
  int err_count = 0, compares = 0, acc_n = 0, acc_o = 0;
  logic old_rstn = 1'h0;
  wire o_valid, o_lvl, o_trg, o_acc;
  wire [7:0] o_vec;
  wire [2:0] o_dm;
  logic [31:0] rd, d0;
  logic [1:0] rs;
  always #2.5 aclk = ~aclk;
  ipds_top #(.NEWER_VARIANT(1)) i_dut (.*);
  ipds_peer i_peer (.*);
  // The older variant takes its own messages at once.
  ipds_top #(.NEWER_VARIANT(0)) i_old
  (
    .*,
    .aresetn       (old_rstn),
    .s_axi_awready (),
    .s_axi_wready  (),
    .s_axi_bresp   (),
    .s_axi_bvalid  (),
    .s_axi_arready (),
    .s_axi_rdata   (),
    .s_axi_rresp   (),
    .s_axi_rvalid  (),
    .msg_valid     (o_valid),
    .msg_ready     (o_valid),
    .msg_vector    (o_vec),
    .msg_delivery  (o_dm),
    .msg_logical   (),
    .msg_level     (o_lvl),
    .msg_trigger   (o_trg),
    .msg_dest      (),
    .msg_incl_self (),
    .msg_excl_self (),
    .rx_accept     (o_acc)
  );
  always @(posedge aclk)
  begin
    if (rx_accept === 1'h1) acc_n <= acc_n + 1;
    if (o_acc === 1'h1) acc_o <= acc_o + 1;
  end
  // ---------------------------------------------------------------
  // Bus tasks.
  // ---------------------------------------------------------------
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic da, dw;
    da = 1'h0;
    dw = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do
    begin
      @(negedge aclk);
      if (s_axi_awvalid && s_axi_awready) da = 1'h1;
      if (s_axi_wvalid && s_axi_wready) dw = 1'h1;
      @(posedge aclk);
      if (da) s_axi_awvalid <= 1'h0;
      if (dw) s_axi_wvalid <= 1'h0;
    end
    while (!(da && dw));
    s_axi_bready <= 1'h1;
    do @(negedge aclk); while (s_axi_bvalid !== 1'h1);
    rs = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'h0;
  endtask
  task automatic rdr(input logic [5:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(negedge aclk); while (s_axi_arready !== 1'h1);
    @(posedge aclk);
    s_axi_arvalid <= 1'h0;
    s_axi_rready <= 1'h1;
    do @(negedge aclk); while (s_axi_rvalid !== 1'h1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'h0;
  endtask
  task automatic wmsg;
    do @(negedge aclk); while (!(msg_valid === 1'h1 && msg_ready === 1'h1));
  endtask
  function automatic logic [31:0] interrupt_command_register(logic [1:0] sh, logic [2:0] dm,
                                      logic lg, logic [7:0] v);
    return {12'h000, sh, 2'h0, 1'h1, 1'h1, 2'h0, lg, dm, v};
  endfunction
  task automatic rx_case(input logic lg, ex, input logic [7:0] d, input int n);
    acc_n = 0;
    i_peer.send(d, lg, ex);
    repeat (6) @(posedge aclk);
    `CHK("accepts", n, acc_n)
  endtask
  // ---------------------------------------------------------------
  // Scenarios.
  // ---------------------------------------------------------------
  task automatic t_regs;
    rdr(6'h0c);
    `CHK("format reset", 32'hffffffff, rd)
    rdr(6'h08);
    `CHK("logical id reset", 32'h0, rd)
    rdr(6'h1c);
    `CHK("unmapped", 34'h200000000, {rs, rd})
  endtask
  task automatic t_send;
    i_peer.delay = 8;
    wr(6'h04, 32'h23000000);
    wr(6'h00, interrupt_command_register(2'h0, 3'h0, 1'h1, 8'h41));
    `CHK("send resp", 2'h0, rs)
    wr(6'h00, interrupt_command_register(2'h0, 3'h0, 1'h1, 8'h42));
    `CHK("busy resp", 2'h2, rs)
    wmsg;
    `CHK("vector", 8'h41, msg_vector)
    `CHK("logical", 9'h123, {msg_logical, msg_dest})
    `CHK("level trig", 2'h2, {msg_level, msg_trigger})
    i_peer.delay = 0;
    wr(6'h04, 32'hfe000000);
    wr(6'h00, interrupt_command_register(2'h0, 3'h4, 1'h0, 8'h02));
    wmsg;
    `CHK("phys", 12'h4fe, {msg_logical, msg_delivery, msg_dest})
  endtask
  task automatic t_short;
    logic [2:0] dms [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
    foreach (dms[i])
    begin
      wr(6'h00, interrupt_command_register(`IPDS_SH_ALL_EXCL, dms[i], 1'h1, 8'h30));
      wmsg;
      `CHK("excl dest", 9'h0ff, {msg_logical, msg_dest})
      `CHK("lowest self", dms[i] == 3'h1, msg_incl_self)
      `CHK("excl self", dms[i] != 3'h1, msg_excl_self)
    end
    wr(6'h18, 32'h5);
    wr(6'h00, interrupt_command_register(`IPDS_SH_SELF, 3'h0, 1'h1, 8'h31));
    wmsg;
    `CHK("self dest", 9'h005, {msg_logical, msg_dest})
    wr(6'h00, interrupt_command_register(`IPDS_SH_ALL_INCL, 3'h0, 1'h0, 8'h32));
    wmsg;
    `CHK("all incl", 9'h1ff, {msg_incl_self, msg_dest})
    rdr(6'h10);
    d0 = rd;
    wr(6'h00, interrupt_command_register(`IPDS_SH_SELF, 3'h1, 1'h0, 8'h33));
    rdr(6'h10);
    `CHK("drops", d0 + 32'h1, rd)
    `CHK("no message", 1'h0, msg_valid)
  endtask
  task automatic t_rx;
    wr(6'h08, 32'h12000000);
    rx_case(1'h0, 1'h0, 8'h05, 3);
    rx_case(1'h0, 1'h0, 8'h06, 0);
    rx_case(1'h0, 1'h0, 8'hff, 3);
    rx_case(1'h0, 1'h1, 8'hff, 0);
    rx_case(1'h1, 1'h0, 8'h02, 3);
    rx_case(1'h1, 1'h0, 8'h01, 0);
    wr(6'h0c, 32'h0fffffff);
    rdr(6'h0c);
    `CHK("format", 32'h0fffffff, rd)
    rx_case(1'h1, 1'h0, 8'h13, 3);
    rx_case(1'h1, 1'h0, 8'h21, 0);
    rx_case(1'h1, 1'h0, 8'hf2, 3);
  endtask
  task automatic t_old;
    // The older part sat in reset so far and never saw undefined cases.
    old_rstn <= 1'h1;
    wr(6'h00, interrupt_command_register(2'h0, `IPDS_DM_FIXED, 1'h0, 8'h51));
    `CHK("old level", 10'h146, {o_vec, o_lvl, o_trg})
    wr(6'h00, interrupt_command_register(2'h0, `IPDS_DM_INIT, 1'h0, 8'h52) & 32'hffffbfff);
    `CHK("old deassert", 5'h14, {o_dm, o_lvl, o_trg})
    acc_o = 0;
    rx_case(1'h0, 1'h0, 8'h0f, 0);
    `CHK("old bcast", 3, acc_o)
  endtask
  task automatic summarize;
    $display("err_count %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs;
    t_send;
    t_short;
    t_rx;
    t_old;
    summarize;
  end
  initial
  begin
    #20000;
    err_count++;
    summarize;
  end
endmodule
